// ==== mdh_pkg.sv ====
package mdh_pkg;
  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CON = 8'h00;
  localparam logic [7:0] ADDR_STA = 8'h04;
  localparam logic [7:0] ADDR_STA1 = 8'h08;
  localparam logic [7:0] ADDR_DAT = 8'h0C;
  localparam logic [7:0] ADDR_ANC = 8'h10;
  localparam logic [7:0] ADDR_VOL = 8'h14;
  localparam logic [7:0] ADDR_VOR = 8'h18;
  localparam logic [7:0] ADDR_BAS = 8'h1C;
  localparam logic [7:0] ADDR_MED = 8'h20;
  localparam logic [7:0] ADDR_TRE = 8'h24;
  localparam logic [7:0] ADDR_CLK = 8'h28;
  localparam logic [7:0] ADDR_IEN = 8'h2C;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CON_EN = 7;
  localparam int CON_BBST = 6;
  localparam int CON_CRCPLAY = 5;
  localparam int STA_ANC = 7;
  localparam int STA_REQ = 6;
  localparam int STA_LAY = 5;
  localparam int STA_SYN = 4;
  localparam int STA_CRC = 3;
  localparam int STA1_FREQ = 4;
  localparam int STA1_BREQ = 3;
  localparam int IEN_EA = 7;
  localparam int IEN_EDEC = 0;
  // ****************************************
  // reset values, sizes and response codes
  // ****************************************
  localparam logic [7:0] CON_RST = 8'h3F;
  localparam logic [4:0] CODE_RST = 5'h1F;
  localparam logic [4:0] CLKDIV_RST = 5'h01;
  localparam logic [10:0] FIRST_REQ_BYTES = 11'h400;
  localparam logic [10:0] FRAME_BYTES = 11'h100;
  localparam int ANC_DEPTH = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mdh_pkg

// ==== mdh_top.sv ====
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module mdh_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pll_clk,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // decode datapath side
  input wire logic dp_frame_done,
  input wire logic dp_layer_err,
  input wire logic dp_sync_err,
  input wire logic dp_crc_err,
  input wire logic dp_hdr_valid,
  input wire logic dp_version,
  input wire logic [1:0] dp_rate,
  input wire logic dp_anc_valid,
  input wire logic [7:0] dp_anc_byte,
  output logic dp_anc_ready,
  output logic dp_byte_valid,
  output logic [7:0] dp_byte,
  output logic dp_frame_start,
  output logic dp_crc_frame_play,
  output logic dp_bass_boost,
  output logic [4:0] dp_left_volume,
  output logic [4:0] dp_right_volume,
  output logic [4:0] dp_low_gain,
  output logic [4:0] dp_mid_gain,
  output logic [4:0] dp_high_gain,
  output logic dec_clk,
  // interrupt to cpu
  output logic dec_irq
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0] con_r;
  logic [4:0] lvol_r, rvol_r, lgain_r, mgain_r, hgain_r, clkdiv_r;
  logic [7:0] ien_r;
  logic layer_flag_r, sync_flag_r, crc_flag_r, ver_r;
  logic [1:0] rate_r;
  logic data_req_r, frame_req_r, byte_req_r, first_done_r;
  logic [10:0] req_left_r;
  localparam int ANC_DEPTH_L = mdh_pkg::ANC_DEPTH;
  logic [7:0] anc_mem [ANC_DEPTH_L];
  logic [3:0] anc_wp_r, anc_rp_r;
  logic [7:0] byte_r;
  logic byte_valid_r, frame_start_r, frame_busy_r;
  logic aw_got_r, w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] rdata_r;

  wire en = con_r[mdh_pkg::CON_EN];
  wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire sta_rd = rd_go && s_axi_araddr == mdh_pkg::ADDR_STA;
  wire anc_rd = rd_go && s_axi_araddr == mdh_pkg::ADDR_ANC;
  wire dat_wr = wr_go && aw_addr_r == mdh_pkg::ADDR_DAT && wstrb_r[0];
  wire anc_empty = anc_wp_r == anc_rp_r;
  wire anc_full = anc_wp_r == {~anc_rp_r[3], anc_rp_r[2:0]};

  function automatic logic known(input logic [7:0] a);
    known = a <= mdh_pkg::ADDR_IEN && a[1:0] == 2'h0;
  endfunction : known

  // ****************************************
  // axi4-lite slave
  // ****************************************
  assign s_axi_awready = !aw_got_r;
  assign s_axi_wready = !w_got_r;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mdh_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(aw_addr_r) ? mdh_pkg::RESP_OKAY : mdh_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rdata_r = 32'h00000000;
    case (s_axi_araddr)
      mdh_pkg::ADDR_CON: rdata_r[7:0] = con_r;
      mdh_pkg::ADDR_STA: rdata_r[7:0] = {!anc_empty, data_req_r, layer_flag_r, sync_flag_r,
                                         crc_flag_r, rate_r, ver_r};
      mdh_pkg::ADDR_STA1: rdata_r[7:0] = {3'h0, frame_req_r, byte_req_r, 3'h0};
      mdh_pkg::ADDR_ANC: rdata_r[7:0] = anc_mem[anc_rp_r[2:0]];
      mdh_pkg::ADDR_VOL: rdata_r[4:0] = lvol_r;
      mdh_pkg::ADDR_VOR: rdata_r[4:0] = rvol_r;
      mdh_pkg::ADDR_BAS: rdata_r[4:0] = lgain_r;
      mdh_pkg::ADDR_MED: rdata_r[4:0] = mgain_r;
      mdh_pkg::ADDR_TRE: rdata_r[4:0] = hgain_r;
      mdh_pkg::ADDR_CLK: rdata_r[4:0] = clkdiv_r;
      mdh_pkg::ADDR_IEN: rdata_r[7:0] = ien_r;
      default: rdata_r = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= mdh_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_r;
      s_axi_rresp <= known(s_axi_araddr) ? mdh_pkg::RESP_OKAY : mdh_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // control and audio settings
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      con_r <= mdh_pkg::CON_RST;
      lvol_r <= mdh_pkg::CODE_RST;
      rvol_r <= mdh_pkg::CODE_RST;
      lgain_r <= mdh_pkg::CODE_RST;
      mgain_r <= mdh_pkg::CODE_RST;
      hgain_r <= mdh_pkg::CODE_RST;
      clkdiv_r <= mdh_pkg::CLKDIV_RST;
      ien_r <= 8'h00;
    end else if (wr_go && wstrb_r[0]) begin
      case (aw_addr_r)
        mdh_pkg::ADDR_CON: con_r <= wdata_r[7:0];
        mdh_pkg::ADDR_VOL: lvol_r <= wdata_r[4:0];
        mdh_pkg::ADDR_VOR: rvol_r <= wdata_r[4:0];
        mdh_pkg::ADDR_BAS: lgain_r <= wdata_r[4:0];
        mdh_pkg::ADDR_MED: mgain_r <= wdata_r[4:0];
        mdh_pkg::ADDR_TRE: hgain_r <= wdata_r[4:0];
        mdh_pkg::ADDR_CLK: clkdiv_r <= wdata_r[4:0];
        mdh_pkg::ADDR_IEN: ien_r <= wdata_r[7:0];
        default: con_r <= con_r;
      endcase
    end
  end

  assign dp_left_volume = lvol_r;
  assign dp_right_volume = rvol_r;
  assign dp_low_gain = lgain_r;
  assign dp_mid_gain = mgain_r;
  assign dp_high_gain = hgain_r;
  assign dp_bass_boost = con_r[mdh_pkg::CON_BBST];
  assign dp_crc_frame_play = con_r[mdh_pkg::CON_CRCPLAY];

  // ****************************************
  // decoder clock divider
  // ****************************************
  // pll_clk is its own domain: reset and divider word each pass two flops first;
  // a new word is taken only once two samples agree, so a skewed bit never lands
  logic pll_rst_s1_r, pll_rst_s2_r;
  logic [4:0] div_s1_r, div_s2_r, div_s3_r, div_use_r, div_cnt_r;
  logic dec_clk_r;
  always_ff @(posedge pll_clk) begin
    pll_rst_s1_r <= rst;
    pll_rst_s2_r <= pll_rst_s1_r;
    div_s1_r <= clkdiv_r;
    div_s2_r <= div_s1_r;
    div_s3_r <= div_s2_r;
  end

  always_ff @(posedge pll_clk) begin
    if (pll_rst_s2_r) begin
      div_use_r <= mdh_pkg::CLKDIV_RST;
      div_cnt_r <= 5'h00;
      dec_clk_r <= 1'b0;
    end else begin
      if (div_s2_r == div_s3_r) div_use_r <= div_s3_r;
      // odd ratios of 3 and up give uneven duty
      if (div_cnt_r >= div_use_r - 5'h01 || div_use_r == 5'h00) begin
        div_cnt_r <= 5'h00;
        dec_clk_r <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + 5'h01;
        dec_clk_r <= div_cnt_r + 5'h01 < {1'b0, div_use_r[4:1]};
      end
    end
  end
  // ratios 0 and 1 pass pll_clk straight through; switching into or out of them may glitch once
  assign dec_clk = div_use_r <= 5'h01 ? pll_clk : dec_clk_r;

  // ****************************************
  // input data handshake
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst || !en) begin
      data_req_r <= 1'b0;
      frame_req_r <= 1'b0;
      byte_req_r <= 1'b0;
      first_done_r <= 1'b0;
      req_left_r <= 11'h000;
      frame_busy_r <= 1'b0;
      frame_start_r <= 1'b0;
    end else begin
      frame_start_r <= 1'b0;
      if (!frame_req_r && !frame_busy_r) begin
        frame_req_r <= 1'b1;
        data_req_r <= 1'b1;
        byte_req_r <= 1'b1;
        req_left_r <= first_done_r ? mdh_pkg::FRAME_BYTES : mdh_pkg::FIRST_REQ_BYTES;
      end else if (frame_req_r && dat_wr) begin
        byte_req_r <= ~byte_req_r;
        req_left_r <= req_left_r - 11'h001;
        if (req_left_r == 11'h001) begin
          frame_req_r <= 1'b0;
          data_req_r <= 1'b0;
          first_done_r <= 1'b1;
          frame_busy_r <= 1'b1;
          frame_start_r <= 1'b1;
        end
      end else if (frame_busy_r && dp_frame_done) begin
        frame_busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      byte_valid_r <= 1'b0;
      byte_r <= 8'h00;
    end else begin
      byte_valid_r <= dat_wr && frame_req_r && en;
      if (dat_wr) byte_r <= wdata_r[7:0];
    end
  end
  assign dp_byte_valid = byte_valid_r;
  assign dp_byte = byte_r;
  assign dp_frame_start = frame_start_r;

  // ****************************************
  // error flags and frame info
  // ****************************************
  // set wins over the clear of a status read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      layer_flag_r <= 1'b0;
      sync_flag_r <= 1'b0;
      crc_flag_r <= 1'b0;
      ver_r <= 1'b1;
      rate_r <= 2'h0;
    end else begin
      layer_flag_r <= (en && dp_layer_err) || (layer_flag_r && !sta_rd);
      sync_flag_r <= (en && dp_sync_err) || (sync_flag_r && !sta_rd);
      crc_flag_r <= (en && dp_crc_err) || (crc_flag_r && !sta_rd);
      if (en && dp_hdr_valid) begin
        ver_r <= dp_version;
        rate_r <= dp_rate;
      end
    end
  end

  // ****************************************
  // ancillary buffer
  // ****************************************
  assign dp_anc_ready = !anc_full;
  always_ff @(posedge sys_clk) begin
    if (rst || !en) begin
      anc_wp_r <= 4'h0;
      anc_rp_r <= 4'h0;
    end else begin
      if (dp_anc_valid && !anc_full) begin
        anc_mem[anc_wp_r[2:0]] <= dp_anc_byte;
        anc_wp_r <= anc_wp_r + 4'h1;
      end
      if (anc_rd && !anc_empty) anc_rp_r <= anc_rp_r + 4'h1;
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  wire [4:0] flags = {!anc_empty, data_req_r, layer_flag_r, sync_flag_r, crc_flag_r};
  wire any_src = |(flags & ~con_r[4:0]);
  always_ff @(posedge sys_clk) begin
    if (rst) dec_irq <= 1'b0;
    else dec_irq <= any_src && ien_r[mdh_pkg::IEN_EDEC] && ien_r[mdh_pkg::IEN_EA];
  end
endmodule : mdh_top

// ==== mdh_checker.sv ====
`timescale 1ns/1ns
module mdh_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register bus writes
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  // datapath side
  input wire logic dp_byte_valid,
  input wire logic dp_frame_start,
  input wire logic dp_crc_frame_play,
  input wire logic dp_bass_boost,
  input wire logic [4:0] dp_left_volume,
  input wire logic [4:0] dp_right_volume,
  input wire logic [4:0] dp_low_gain,
  input wire logic [4:0] dp_mid_gain,
  input wire logic [4:0] dp_high_gain
);
  logic [7:0] wa_r;
  logic [7:0] wd_r;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // settings land on the edge that raises bvalid, so keep what was taken
  always_ff @(posedge sys_clk) begin
    if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[7:0];
  end
  sequence s_wr(logic [7:0] a);
    $rose(s_axi_bvalid) && s_axi_bresp == mdh_pkg::RESP_OKAY && wa_r == a;
  endsequence
  property p_code(logic [7:0] a, logic [4:0] f);
    s_wr(a) |-> f == wd_r[4:0];
  endproperty
  chk_left_volume: assert property (p_code(mdh_pkg::ADDR_VOL, dp_left_volume))
    else $error("left volume not applied");
  chk_right_volume: assert property (p_code(mdh_pkg::ADDR_VOR, dp_right_volume))
    else $error("right volume not applied");
  chk_low_gain: assert property (p_code(mdh_pkg::ADDR_BAS, dp_low_gain))
    else $error("low band gain not applied");
  chk_mid_gain: assert property (p_code(mdh_pkg::ADDR_MED, dp_mid_gain))
    else $error("mid band gain not applied");
  chk_high_gain: assert property (p_code(mdh_pkg::ADDR_TRE, dp_high_gain))
    else $error("high band gain not applied");
  chk_boost_bit: assert property (s_wr(mdh_pkg::ADDR_CON) |-> dp_bass_boost == wd_r[6])
    else $error("bass boost not applied");
  chk_crc_play: assert property (s_wr(mdh_pkg::ADDR_CON) |-> dp_crc_frame_play == wd_r[5])
    else $error("crc play choice not applied");
  chk_codes_hold: assert property (!$stable({dp_left_volume, dp_right_volume, dp_low_gain,
      dp_mid_gain, dp_high_gain, dp_bass_boost, dp_crc_frame_play}) |-> $rose(s_axi_bvalid))
    else $error("setting moved without a write");
  chk_start_after: assert property (dp_frame_start |-> dp_byte_valid || $past(dp_byte_valid)
      || $past(dp_byte_valid, 2))
    else $error("frame start without a final byte");
  chk_byte_once: assert property (dp_byte_valid |=> !dp_byte_valid)
    else $error("one write gave two bytes");
endmodule : mdh_checker

// ==== mdh_cpu_model.sv ====
`timescale 1ns/1ns
module mdh_cpu_model (
  // clock
  input wire logic sys_clk,
  // write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
  end
  // each stream byte written acknowledges the pending request
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // spare edge so a following call never reassigns bready in this step
    @(posedge sys_clk);
  endtask : wr
  // status reads clear flags, so the caller keeps the returned copy
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
endmodule : mdh_cpu_model

// ==== mdh_top_tb.sv ====
`timescale 1ns/1ns
module mdh_top_tb;
  logic sys_clk = 1'b0;
  logic pll_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr, dp_byte;
  logic [7:0] dp_anc_byte = 8'h00;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [1:0] dp_rate = 2'h0;
  logic [4:0] dp_left_volume, dp_right_volume, dp_low_gain, dp_mid_gain, dp_high_gain;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dp_anc_ready, dp_byte_valid;
  logic dp_frame_start, dp_crc_frame_play, dp_bass_boost, dec_clk, dec_irq;
  logic dp_frame_done = 1'b0, dp_layer_err = 1'b0, dp_sync_err = 1'b0, dp_crc_err = 1'b0;
  logic dp_hdr_valid = 1'b0, dp_version = 1'b0, dp_anc_valid = 1'b0;
  int n_mismatch = 0, samples_checked = 0, cycles = 0, starts = 0;
  mdh_top dut (.*);
  mdh_cpu_model cpu (.*);
  always #20 sys_clk = ~sys_clk;
  always #7 pll_clk = ~pll_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (dp_frame_start) starts <= starts + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    cpu.wr(a, d, rr);
    cmp({30'h0, rr}, {30'h0, mdh_pkg::RESP_OKAY}, "bresp");
  endtask : w
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    cpu.rd(a, rv, rr);
    cmp({30'h0, rr}, {30'h0, mdh_pkg::RESP_OKAY}, "rresp");
    cmp(rv, exp, what);
  endtask : rchk
  task automatic irqc(input logic exp, input string what);
    repeat (2) @(posedge sys_clk);
    cmp({31'h0, dec_irq}, {31'h0, exp}, what);
  endtask : irqc
  task automatic t_reset;
    cmp({7'h0, dp_left_volume, dp_right_volume, dp_low_gain, dp_mid_gain, dp_high_gain}, 32'h01FFFFFF, "codes");
    rchk(mdh_pkg::ADDR_CON, 32'h3F, "con");
    rchk(mdh_pkg::ADDR_STA, 32'h01, "sta");
    rchk(mdh_pkg::ADDR_IEN, 32'h00, "ien");
    cpu.rd(8'h3C, rv, rr);
    cmp({rr, rv[29:0]}, {mdh_pkg::RESP_SLVERR, 30'h0}, "unmapped");
  endtask : t_reset
  task automatic t_codes;
    logic [4:0] c;
    for (int k = 0; k < 4; k++) begin
      c = (k[1] ? 5'h1E : 5'h00) | {4'h0, k[0]};
      for (int i = 0; i < 5; i++) w(mdh_pkg::ADDR_VOL + 8'(4 * i), {27'h0, c});
      cmp({7'h0, dp_left_volume, dp_right_volume, dp_low_gain, dp_mid_gain, dp_high_gain},
        {7'h0, {5{c}}}, "codes");
      rchk(mdh_pkg::ADDR_MED, {27'h0, c}, "med");
    end
  endtask : t_codes
  task automatic t_stream;
    w(mdh_pkg::ADDR_CON, 32'hE0);
    rchk(mdh_pkg::ADDR_STA1, 32'h18, "req");
    rchk(mdh_pkg::ADDR_STA, 32'h41, "req sta");
    for (int i = 0; i < 1024; i++) begin
      w(mdh_pkg::ADDR_DAT, {24'h0, 8'(i)});
      if (i < 2 || i == 1022) rchk(mdh_pkg::ADDR_STA1, i[0] ? 32'h18 : 32'h10, "byte flag");
      if (i == 1022) cmp(starts, 0, "early start");
    end
    rchk(mdh_pkg::ADDR_STA1, 32'h08, "frame done");
    cmp(starts, 1, "start");
    cmp({24'h0, dp_byte}, 32'hFF, "last byte");
    dp_frame_done <= 1'b1;
    @(posedge sys_clk);
    dp_frame_done <= 1'b0;
    @(posedge sys_clk);
    rchk(mdh_pkg::ADDR_STA1, 32'h18, "next req");
    for (int i = 0; i < 256; i++) w(mdh_pkg::ADDR_DAT, 32'h5A);
    cmp(starts, 2, "start 2");
  endtask : t_stream
  task automatic t_errors;
    for (int k = 0; k < 3; k++) begin
      {dp_layer_err, dp_sync_err, dp_crc_err} <= 3'h4 >> k;
      @(posedge sys_clk);
      {dp_layer_err, dp_sync_err, dp_crc_err} <= 3'h0;
      rchk(mdh_pkg::ADDR_STA, (32'h20 >> k) | 32'h01, "err");
      rchk(mdh_pkg::ADDR_STA, 32'h01, "err clear");
    end
  endtask : t_errors
  task automatic t_info;
    for (int k = 0; k < 6; k++) begin
      {dp_version, dp_rate} <= {k[0], 2'(k >> 1)};
      dp_hdr_valid <= 1'b1;
      @(posedge sys_clk);
      dp_hdr_valid <= 1'b0;
      rchk(mdh_pkg::ADDR_STA, {29'h0, 2'(k >> 1), k[0]}, "info");
    end
    w(mdh_pkg::ADDR_CLK, 32'h02);
    rchk(mdh_pkg::ADDR_CLK, 32'h02, "div");
  endtask : t_info
  task automatic t_div;
    time t0;
    for (int d = 1; d < 4; d++) begin
      w(mdh_pkg::ADDR_CLK, 32'(d));
      repeat (4) @(posedge sys_clk);
      @(posedge dec_clk);
      t0 = $time;
      @(posedge dec_clk);
      cmp(32'($time - t0), 32'(14 * d), "div period");
    end
  endtask : t_div
  task automatic t_anc;
    dp_anc_valid <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      dp_anc_byte <= 8'hA5 ^ 8'(i);
      do @(posedge sys_clk); while (!dp_anc_ready);
    end
    dp_anc_valid <= 1'b0;
    rchk(mdh_pkg::ADDR_STA, 32'h85, "anc flag");
    rchk(mdh_pkg::ADDR_ANC, 32'hA5, "anc 0");
    rchk(mdh_pkg::ADDR_STA, 32'h85, "anc held");
    rchk(mdh_pkg::ADDR_ANC, 32'hA4, "anc 1");
    rchk(mdh_pkg::ADDR_STA, 32'h05, "anc empty");
  endtask : t_anc
  task automatic t_irq;
    w(mdh_pkg::ADDR_IEN, 32'h81);
    irqc(1'b0, "quiet");
    dp_sync_err <= 1'b1;
    @(posedge sys_clk);
    dp_sync_err <= 1'b0;
    irqc(1'b1, "sync");
    w(mdh_pkg::ADDR_CON, 32'hE2);
    irqc(1'b0, "masked");
    w(mdh_pkg::ADDR_CON, 32'hE0);
    irqc(1'b1, "unmasked");
    w(mdh_pkg::ADDR_IEN, 32'h80);
    irqc(1'b0, "no dec enable");
    w(mdh_pkg::ADDR_IEN, 32'h01);
    irqc(1'b0, "no global");
    w(mdh_pkg::ADDR_IEN, 32'h81);
    rchk(mdh_pkg::ADDR_STA, 32'h15, "sync flag");
    irqc(1'b0, "acked");
    dp_frame_done <= 1'b1;
    @(posedge sys_clk);
    dp_frame_done <= 1'b0;
    @(posedge sys_clk);
    irqc(1'b1, "req src");
    w(mdh_pkg::ADDR_CON, 32'hE8);
    irqc(1'b0, "req masked");
    dp_anc_valid <= 1'b1;
    @(posedge sys_clk);
    dp_anc_valid <= 1'b0;
    irqc(1'b1, "anc src");
    w(mdh_pkg::ADDR_CON, 32'hF8);
    irqc(1'b0, "anc masked");
    w(mdh_pkg::ADDR_CON, 32'h60);
    dp_layer_err <= 1'b1;
    @(posedge sys_clk);
    dp_layer_err <= 1'b0;
    rchk(mdh_pkg::ADDR_STA, 32'h05, "disabled");
  endtask : t_irq
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_codes();
    t_stream();
    t_errors();
    t_info();
    t_div();
    t_anc();
    t_irq();
    print_verdict();
  end
endmodule : mdh_top_tb
bind mdh_top mdh_checker chk (.*);
